// ==== rtl/sertx_defines.svh ====
// Purpose: shared constants of the serializer transmit path
// Assumes: included by bare name from every design file that needs it
// Notes:   definitions only
`ifndef SERTX_DEFINES_SVH
`define SERTX_DEFINES_SVH

// register map
`define SERTX_CTRL_OFF     8'h00
`define SERTX_STAT_OFF     8'h04

// control register fields
`define SERTX_CTRL_INSEL   0
`define SERTX_CTRL_RATE    1
`define SERTX_CTRL_SPD_LO  2
`define SERTX_CTRL_SPD_HI  3
`define SERTX_CTRL_DRV1    4
`define SERTX_CTRL_DRV2    5
`define SERTX_CTRL_BIST    6
`define SERTX_CTRL_PABRST  7
`define SERTX_CTRL_W       8
`define SERTX_CTRL_RST     8'h80

// status register fields
`define SERTX_STAT_ERR     0
`define SERTX_STAT_PWRDN   1
`define SERTX_STAT_RSVD    2
`define SERTX_STAT_BYPASS  3
`define SERTX_STAT_BIST    4
`define SERTX_STAT_W       5

// character values and clock multiplier factors
`define SERTX_ERR_CHAR     10'h278
`define SERTX_IDLE_CHAR    10'h000
`define SERTX_MULT_FULL    5'h0A
`define SERTX_MULT_HALF    5'h14

// self-test generator
`define SERTX_LFSR_SEED    9'h1FF
`define SERTX_LFSR_TAP_A   8
`define SERTX_LFSR_TAP_B   4

// phase-align buffer geometry
`define SERTX_PAB_DEPTH    4
`define SERTX_PAB_PTR_W    2
`define SERTX_PAB_CNT_W    3
`define SERTX_PAB_INIT_GAP 2'h2
`define SERTX_PAB_INIT_CNT 3'h2
`define SERTX_PAB_FULL     3'h4
`define SERTX_PAB_EMPTY    3'h0

// character clock output high time in system clocks
`define SERTX_CKO_HOLD     2'h2

`endif

// ==== rtl/sertx_lfsr.sv ====
// Purpose: self-test character generator, 511-character period
// Assumes: step is a single-cycle pulse per character
// Notes:   polynomial x^9 + x^5 + 1, matched to the receive checker
`timescale 1ns/1ps
`include "sertx_defines.svh"

module sertx_lfsr
  import sertx_pkg::*;
(
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // control
  input  wire logic  enable,
  input  wire logic  step,
  // generated character
  output sertx_char_t char_out
);

  logic [8:0] state_reg;
  logic       feedback;

  assign feedback = state_reg[`SERTX_LFSR_TAP_A] ^ state_reg[`SERTX_LFSR_TAP_B];
  assign char_out = {feedback, state_reg};

  // reload seed whenever disabled so each run starts the same sequence
  always_ff @(posedge clk)
  begin
    if (!rst_n || !enable)
      state_reg <= `SERTX_LFSR_SEED;
    else if (step)
      state_reg <= {state_reg[7:0], feedback};
  end

endmodule

// ==== rtl/sertx_phase_buf.sv ====
// Purpose: phase-align buffer between capture strobe and character tick
// Assumes: wr_en and rd_en are single-cycle pulses on clk
// Notes:   error is sticky until init; starts half full to absorb drift
`timescale 1ns/1ps
`include "sertx_defines.svh"

module sertx_phase_buf
  import sertx_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        init,
  // write side
  input  wire logic        wr_en,
  input  wire sertx_char_t wr_data,
  // read side
  input  wire logic        rd_en,
  output sertx_char_t      rd_data,
  output logic             error
);

  logic [`SERTX_PAB_PTR_W-1:0] wr_ptr_reg;
  logic [`SERTX_PAB_PTR_W-1:0] rd_ptr_reg;
  logic [`SERTX_PAB_CNT_W-1:0] cnt_reg;
  sertx_char_t                 mem [`SERTX_PAB_DEPTH];
  logic                        overflow;
  logic                        underflow;

  // one write port per entry
  for (genvar i = 0; i < `SERTX_PAB_DEPTH; i++)
  begin : g_entry
    always_ff @(posedge clk)
    begin
      if (wr_en && !overflow && (wr_ptr_reg == `SERTX_PAB_PTR_W'(i)))
        mem[i] <= wr_data;
    end
  end

  // drift of two characters either way empties or fills the ring
  assign overflow  = wr_en && !rd_en && (cnt_reg == `SERTX_PAB_FULL);
  assign underflow = rd_en && !wr_en && (cnt_reg == `SERTX_PAB_EMPTY);

  // pointers and fill level; init recentres the ring
  always_ff @(posedge clk)
  begin
    if (!rst_n || init)
    begin
      wr_ptr_reg <= `SERTX_PAB_INIT_GAP;
      rd_ptr_reg <= '0;
      cnt_reg    <= `SERTX_PAB_INIT_CNT;
    end
    else if (!error)
    begin
      if (wr_en && !overflow)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (rd_en && !underflow)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (wr_en && !rd_en && !overflow)
        cnt_reg <= cnt_reg + 1'b1;
      else if (rd_en && !wr_en && !underflow)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // read data register
  always_ff @(posedge clk)
  begin
    if (!rst_n || init)
      rd_data <= `SERTX_IDLE_CHAR;
    else if (rd_en && !underflow)
      rd_data <= mem[rd_ptr_reg];
  end

  // sticky error, cleared only by init or reset; a slip in the init cycle wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      error <= 1'b0;
    else if (overflow || underflow)
      error <= 1'b1;
    else if (init)
      error <= 1'b0;
  end

endmodule

// ==== rtl/sertx_pkg.sv ====
// Purpose: shared types of the serializer transmit path
// Assumes: nothing
// Notes:   constants live in sertx_defines.svh
package sertx_pkg;

  typedef logic [9:0] sertx_char_t;

  typedef enum logic [1:0] {
    SERTX_SPD_LOW,
    SERTX_SPD_MID,
    SERTX_SPD_HIGH,
    SERTX_SPD_UNUSED
  } sertx_speed_t;

endpackage

// ==== rtl/sertx_top.sv ====
// Purpose: transmit path of a serial-link serializer, sampled model
// Assumes: link clocks are far slower than clk and sampled by it
// Notes:   the bit clock is represented by its multiplier factor output
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "sertx_defines.svh"

// Functional notes
// - input register captures on host clock if select 0, reference clock if 1
// - phase buffer used with host clock, or reference clock at half rate
// - reference clock capture at full rate bypasses the phase buffer
// - buffer absorbs up to two characters of host clock drift
// - drift beyond capacity raises sticky phase error until reinit
// - writing 0 to the phase buffer reset latch reinitializes it
// - after reinit the error drops and capture resumes correctly
// - while in error the fixed error character 1001111000 is sent repeatedly
// - self-test latch turns a register into a 511-character LFSR
// - reset clears the self-test enable latch
// - parallel inputs are ignored while self-test runs
// - bit clock is reference times 10 or 20 by rate select
// - character clock is generated and driven on its output
// - three speed ranges; low range with half rate is reserved
// - each serial driver is enabled alone; disabled means powered down
// - both drivers off powers down the channel transmit logic
// - reset disables all serial drivers
// - phase buffer reset is a dedicated configuration latch
module sertx_top
  import sertx_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // host parallel side
  input  wire logic        host_tx_input_clock,
  input  wire logic        tx_reference_clock,
  input  wire sertx_char_t tx_char_in,
  // status and clocks out
  output logic             tx_phase_error,
  output logic             tx_char_clock_out,
  output logic      [4:0]  tx_bit_mult,
  // serial side
  output sertx_char_t      tx_serial_char,
  output logic             tx_serial_strobe,
  output logic      [1:0]  tx_driver_enable,
  output logic             tx_logic_powered_down
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [`SERTX_CTRL_W-1:0] ctrl_reg;
  logic                     pab_init_reg;
  logic                     host_s1_reg;
  logic                     host_s2_reg;
  logic                     host_s3_reg;
  logic                     ref_s1_reg;
  logic                     ref_s2_reg;
  logic                     ref_s3_reg;
  sertx_char_t              data_s1_reg;
  sertx_char_t              data_s2_reg;
  sertx_char_t              in_reg;
  logic                     cap_q_reg;
  logic [1:0]               cko_cnt_reg;
  logic                     host_rise;
  logic                     ref_rise;
  logic                     ref_fall;
  logic                     insel;
  logic                     half_rate;
  logic                     selftest;
  logic                     bypass;
  logic                     use_buf;
  logic                     powered;
  logic                     capture;
  logic                     char_tick;
  logic                     buf_wr;
  logic                     buf_rd;
  logic                     buf_err;
  logic                     rsvd_combo;
  sertx_char_t              buf_data;
  sertx_char_t              lfsr_char;
  sertx_char_t              char_next;
  sertx_speed_t             speed;
  logic [`SERTX_STAT_W-1:0] status;

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode

  assign insel      = ctrl_reg[`SERTX_CTRL_INSEL];
  assign half_rate  = ctrl_reg[`SERTX_CTRL_RATE];
  assign selftest   = ctrl_reg[`SERTX_CTRL_BIST];
  assign speed      = sertx_speed_t'(ctrl_reg[`SERTX_CTRL_SPD_HI:`SERTX_CTRL_SPD_LO]);
  assign bypass     = insel && !half_rate;
  assign use_buf    = !bypass;
  assign powered    = ctrl_reg[`SERTX_CTRL_DRV1] || ctrl_reg[`SERTX_CTRL_DRV2];
  assign rsvd_combo = (speed == SERTX_SPD_LOW) && half_rate;

  ////////////////////////////////////////////////////////////////////////////
  // register port

  // control latch; reset turns off drivers and self-test
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl_reg <= `SERTX_CTRL_RST;
    else if (reg_wr && (reg_addr == `SERTX_CTRL_OFF))
      ctrl_reg <= reg_wdata[`SERTX_CTRL_W-1:0];
  end

  // a 0 written to the reset latch recentres the phase buffer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pab_init_reg <= 1'b0;
    else
      pab_init_reg <= reg_wr && (reg_addr == `SERTX_CTRL_OFF)
                      && !reg_wdata[`SERTX_CTRL_PABRST];
  end

  // status word
  always_comb
  begin
    status                     = '0;
    status[`SERTX_STAT_ERR]    = tx_phase_error;
    status[`SERTX_STAT_PWRDN]  = tx_logic_powered_down;
    status[`SERTX_STAT_RSVD]   = rsvd_combo;
    status[`SERTX_STAT_BYPASS] = bypass;
    status[`SERTX_STAT_BIST]   = selftest;
  end

  // read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SERTX_CTRL_OFF: reg_rdata <= {{(32-`SERTX_CTRL_W){1'b0}}, ctrl_reg};
        `SERTX_STAT_OFF: reg_rdata <= {{(32-`SERTX_STAT_W){1'b0}}, status};
        default:         reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // two synchroniser flops per pin plus an edge flop on each clock; data delayed alike so it lines up with its clock
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      host_s1_reg <= 1'b0;
      host_s2_reg <= 1'b0;
      host_s3_reg <= 1'b0;
      ref_s1_reg  <= 1'b0;
      ref_s2_reg  <= 1'b0;
      ref_s3_reg  <= 1'b0;
      data_s1_reg <= `SERTX_IDLE_CHAR;
      data_s2_reg <= `SERTX_IDLE_CHAR;
    end
    else
    begin
      host_s1_reg <= host_tx_input_clock;
      host_s2_reg <= host_s1_reg;
      host_s3_reg <= host_s2_reg;
      ref_s1_reg  <= tx_reference_clock;
      ref_s2_reg  <= ref_s1_reg;
      ref_s3_reg  <= ref_s2_reg;
      data_s1_reg <= tx_char_in;
      data_s2_reg <= data_s1_reg;
    end
  end

  assign host_rise = host_s2_reg && !host_s3_reg;
  assign ref_rise  = ref_s2_reg && !ref_s3_reg;
  assign ref_fall  = !ref_s2_reg && ref_s3_reg;

  ////////////////////////////////////////////////////////////////////////////
  // clock multiplier: character tick and bit-rate factor

  // half-rate reference gives a character on each of its edges
  assign char_tick = powered && (half_rate ? (ref_rise || ref_fall) : ref_rise);

  // factor of the bit clock over the reference
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tx_bit_mult <= `SERTX_MULT_FULL;
    else
      tx_bit_mult <= half_rate ? `SERTX_MULT_HALF : `SERTX_MULT_FULL;
  end

  // character clock out: short high pulse per character, fixed width
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cko_cnt_reg       <= '0;
      tx_char_clock_out <= 1'b0;
    end
    else if (char_tick)
    begin
      cko_cnt_reg       <= `SERTX_CKO_HOLD;
      tx_char_clock_out <= 1'b1;
    end
    else if (cko_cnt_reg != '0)
    begin
      cko_cnt_reg       <= cko_cnt_reg - 1'b1;
      tx_char_clock_out <= (cko_cnt_reg != 2'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input register

  assign capture = (insel ? ref_rise : host_rise) && !selftest && powered;

  // capture register plus a delayed strobe for the buffer write
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      in_reg    <= `SERTX_IDLE_CHAR;
      cap_q_reg <= 1'b0;
    end
    else
    begin
      cap_q_reg <= capture;
      if (capture)
        in_reg <= data_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase-align buffer and self-test generator

  assign buf_wr = cap_q_reg && use_buf;
  assign buf_rd = char_tick && use_buf && !selftest;

  sertx_phase_buf u_phase_buf (
    .clk     (clk),
    .rst_n   (rst_n),
    .init    (pab_init_reg),
    .wr_en   (buf_wr),
    .wr_data (in_reg),
    .rd_en   (buf_rd),
    .rd_data (buf_data),
    .error   (buf_err)
  );

  sertx_lfsr u_lfsr (
    .clk      (clk),
    .rst_n    (rst_n),
    .enable   (selftest),
    .step     (char_tick),
    .char_out (lfsr_char)
  );

  // error outranks self-test so a broken link is never masked
  always_comb
  begin
    if (buf_err && use_buf)
      char_next = `SERTX_ERR_CHAR;
    else if (selftest)
      char_next = lfsr_char;
    else if (bypass)
      char_next = in_reg;
    else
      char_next = buf_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit shifter and drivers

  // one character per tick; frozen while the channel is powered down
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_serial_char   <= `SERTX_IDLE_CHAR;
      tx_serial_strobe <= 1'b0;
    end
    else
    begin
      tx_serial_strobe <= char_tick;
      if (char_tick)
        tx_serial_char <= char_next;
    end
  end

  // error flag, driver enables and power state
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_phase_error        <= 1'b0;
      tx_driver_enable      <= 2'h0;
      tx_logic_powered_down <= 1'b1;
    end
    else
    begin
      tx_phase_error        <= buf_err && use_buf;
      tx_driver_enable      <= {ctrl_reg[`SERTX_CTRL_DRV2], ctrl_reg[`SERTX_CTRL_DRV1]};
      tx_logic_powered_down <= !powered;
    end
  end

endmodule

// ==== test/sertx_host_model.sv ====
// Purpose: host side driving characters and link clocks
// Assumes: link clocks far slower than clk
// Notes:   host clock stands low while host_run is low
`timescale 1ns/1ps

module sertx_host_model
  import sertx_pkg::*;
(
  // control from the bench
  input wire logic        host_run,
  input wire sertx_char_t char_value,
  // link pins
  output logic            host_tx_input_clock,
  output logic            tx_reference_clock,
  output sertx_char_t     tx_char_in
);
  ////////////////////////////////////////////////////////////
  // free reference, 800 ns, phase unrelated to clk
  initial
  begin
    tx_reference_clock = 1'b0;
    #37;
    forever #400 tx_reference_clock = ~tx_reference_clock;
  end

  // host clock; data moves on its fall so the rise sees it settled
  initial
  begin
    host_tx_input_clock = 1'b0;
    tx_char_in = 10'h000;
    #283;
    forever
    begin
      #400;
      host_tx_input_clock = host_run ? ~host_tx_input_clock : 1'b0;
      if (!host_tx_input_clock)
        tx_char_in = char_value;
    end
  end
endmodule

// ==== test/sertx_top_properties.sv ====
// Purpose: port checks of the serializer transmit path
// Assumes: one clock domain, top ports only
// Notes:   bound at the foot of this file
`timescale 1ns/1ps

module sertx_chk
  import sertx_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // observed outputs
  input wire logic        tx_phase_error,
  input wire logic        tx_char_clock_out,
  input wire logic [4:0]  tx_bit_mult,
  input wire sertx_char_t tx_serial_char,
  input wire logic        tx_serial_strobe,
  input wire logic [1:0]  tx_driver_enable,
  input wire logic        tx_logic_powered_down
);
  logic       ctrl_wr;
  logic [3:0] wr_hist_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////
  // recent control writes: error may only drop shortly after one
  assign ctrl_wr = reg_wr && (reg_addr == 8'h00);
  always_ff @(posedge clk)
  begin
    wr_hist_reg <= rst_n ? {wr_hist_reg[2:0], ctrl_wr} : 4'h0;
  end

  // latch then output flop: the factor and the enables follow a write by two cycles
  property p_mult;
    ctrl_wr |-> ##2 tx_bit_mult == ($past(reg_wdata[1], 2) ? 5'h14 : 5'h0A);
  endproperty

  chk_mult_by_rate: assert property (p_mult)
    else $error("bit clock factor wrong");
  chk_drv_after_wr: assert property (
    ctrl_wr |-> ##2 tx_driver_enable == $past(reg_wdata[5:4], 2))
    else $error("driver enables wrong");
  chk_pd_both_off: assert property (
    $stable(tx_driver_enable) |-> tx_logic_powered_down == (tx_driver_enable == 2'b00))
    else $error("power-down flag wrong");
  chk_strobe_single: assert property (
    tx_serial_strobe |-> tx_char_clock_out ##1 !tx_serial_strobe)
    else $error("strobe shape wrong");
  chk_cko_width: assert property (
    $rose(tx_char_clock_out) |-> tx_char_clock_out[*2] ##1 !tx_char_clock_out)
    else $error("character clock width wrong");
  chk_quiet_when_off: assert property (
    tx_logic_powered_down && $past(tx_logic_powered_down, 2) |-> !tx_serial_strobe)
    else $error("character sent while powered down");
  chk_err_char: assert property (
    tx_serial_strobe && tx_phase_error && $past(tx_phase_error) |-> tx_serial_char == 10'h278)
    else $error("error character missing");
  chk_err_sticky: assert property (
    $fell(tx_phase_error) |-> wr_hist_reg != 4'h0)
    else $error("phase error dropped without reinit");

  cover property ($rose(tx_phase_error));
  cover property (tx_serial_strobe && tx_serial_char == 10'h278);
  cover property (tx_bit_mult == 5'h14 && !tx_logic_powered_down);
endmodule

bind sertx_top sertx_chk i_sertx_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .tx_phase_error,
  .tx_char_clock_out, .tx_bit_mult, .tx_serial_char, .tx_serial_strobe, .tx_driver_enable,
  .tx_logic_powered_down);

// ==== test/sertx_top_tb_top.sv ====
// Purpose: self-checking bench of the serializer transmit path
// Assumes: 10 MHz clk, link pins from sertx_host_model
// Notes:   no random stimulus
`timescale 1ns/1ps

module sertx_top_tb_top
  import sertx_pkg::*;
;
  logic        clk, rst_n, reg_wr, reg_rd, host_run;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        host_tx_input_clock, tx_reference_clock, tx_phase_error;
  logic        tx_char_clock_out, tx_serial_strobe, tx_logic_powered_down;
  logic [4:0]  tx_bit_mult;
  logic [1:0]  tx_driver_enable;
  sertx_char_t tx_char_in, tx_serial_char, char_value;
  int          num_errors, checks_done;

  sertx_top i_sertx_top (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .host_tx_input_clock, .tx_reference_clock, .tx_char_in, .tx_phase_error, .tx_char_clock_out,
    .tx_bit_mult, .tx_serial_char, .tx_serial_strobe, .tx_driver_enable, .tx_logic_powered_down);
  sertx_host_model i_sertx_host_model (.host_run, .char_value, .host_tx_input_clock,
    .tx_reference_clock, .tx_char_in);

  initial clk = 1'b0;
  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      num_errors++;
      $display("BAD %0t seen %0h want %0h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // register write: one strobe cycle
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= {24'h0, d};
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // register read, data taken in the cycle after the strobe only
  task automatic rd_check(input logic [7:0] a, input logic [7:0] want, input logic [7:0] m = 8'hFF);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(reg_rdata & {24'h0, m}, {24'h0, want});
  endtask

  // next sent character; bounded so a dead tick path cannot hang
  task automatic next_char(output sertx_char_t c);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (tx_serial_strobe !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      num_errors++;
      $display("BAD %0t no character strobe", $time);
      close_out();
    end
    c = tx_serial_char;
  endtask

  task automatic reset_and_check();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(tx_driver_enable, 2'b00);
    check(tx_logic_powered_down, 1'b1);
    check(tx_bit_mult, 5'h0A);
    rd_check(8'h00, 8'h80);
    rd_check(8'h04, 8'h02);
    rd_check(8'h08, 8'h00);
    $display("test reset done");
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin : main
    sertx_char_t c, first;
    logic        seen;
    int          k;
    {num_errors, checks_done} = '0;
    {rst_n, reg_wr, reg_rd, host_run} = 4'b0001;
    {reg_addr, reg_wdata, char_value} = '0;
    reset_and_check();
    // each driver alone, both, none
    for (k = 1; k < 5; k++)
    begin
      reg_write(8'h00, 8'h80 | 8'((k & 3) << 4));
      repeat (2) @(negedge clk);
      check(tx_driver_enable, k & 3);
      check(tx_logic_powered_down, (k & 3) == 0);
    end
    // every speed range with both rates
    for (k = 0; k < 6; k++)
    begin
      reg_write(8'h00, 8'h80 | 8'((k >> 1) << 2) | 8'((k & 1) << 1));
      repeat (3) @(negedge clk);
      check(tx_bit_mult, (k & 1) ? 5'h14 : 5'h0A);
      rd_check(8'h04, (k == 1) ? 8'h06 : 8'h02);
    end
    $display("test drivers and rates done");
    char_value = 10'h155;
    reg_write(8'h00, 8'h91);
    rd_check(8'h04, 8'h08, 8'hFE);
    repeat (4) next_char(c);
    check(c, 10'h155);
    check(tx_char_clock_out, 1'b1);
    reg_write(8'h00, 8'h97);
    rd_check(8'h04, 8'h00, 8'h08);
    $display("test reference capture done");
    char_value = 10'h2AA;
    reg_write(8'h00, 8'h90);
    reg_write(8'h00, 8'h10);
    reg_write(8'h00, 8'h90);
    // settle time after reinitializing the phase buffer in host clock mode
    repeat (2500) @(posedge clk);
    repeat (3) next_char(c);
    host_run = 1'b0;
    #400 host_run = 1'b1;
    repeat (5) next_char(c);
    for (k = 0; k < 6; k++)
    begin
      next_char(c);
      check(c, 10'h2AA);
    end
    check(tx_phase_error, 1'b0);
    host_run = 1'b0;
    for (k = 0; k < 10 && tx_phase_error !== 1'b1; k++)
      next_char(c);
    check(tx_phase_error, 1'b1);
    next_char(c);
    check(c, 10'h278);
    rd_check(8'h04, 8'h01);
    host_run = 1'b1;
    repeat (4) next_char(c);
    check(tx_phase_error, 1'b1);
    check(c, 10'h278);
    reg_write(8'h00, 8'h10);
    reg_write(8'h00, 8'h90);
    repeat (5) next_char(c);
    check(tx_phase_error, 1'b0);
    check(c, 10'h2AA);
    $display("test phase buffer done");
    // self-test period; input changes must not disturb it
    reg_write(8'h00, 8'hD1);
    rd_check(8'h04, 8'h18, 8'hFE);
    repeat (3) next_char(first);
    char_value = 10'h0F0;
    seen = 1'b0;
    for (k = 1; k < 511; k++)
    begin
      next_char(c);
      if (c === first)
        seen = 1'b1;
    end
    check(seen, 1'b0);
    next_char(c);
    check(c, first);
    $display("test self-test done");
    reset_and_check();
    close_out();
  end
endmodule
